/* src/rcs_regs.svh */
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// Minimum power-up reset hold time in microseconds
`define RCS_POR_HOLD_US      3000
// Clock rate in MHz
`define RCS_CLK_MHZ          250
// Cycles for the minimum hold, the exact product of hold time and clock rate
`define RCS_POR_HOLD_CYC     (`RCS_POR_HOLD_US * `RCS_CLK_MHZ)
// Default number of strap pins
`define RCS_STRAP_W          4
// Position of the reference-select strap
`define RCS_STRAP_REF_BIT    0
// Reference select encoding after reset without a strap override
`define RCS_REF_RESET        1'b0
// Reset value of the PLL power-down bit
`define RCS_PLL_POWER_DOWN_BIT_RESET      1'b0

`endif

/* src/rcs_pkg.sv */
package rcs_pkg;

   typedef enum logic [1:0] {
      RCS_ST_POR   = 2'b00,
      RCS_ST_HOLD  = 2'b01,
      RCS_ST_SYNC  = 2'b10,
      RCS_ST_RUN   = 2'b11
   } rcs_state_t;

   typedef enum logic {
      RCS_REF_XTAL = 1'b0,
      RCS_REF_BCLK = 1'b1
   } rcs_ref_t;

   // Clock configuration from the initializing party
   typedef struct packed {
      logic       ref_wr;
      rcs_ref_t   ref_sel;
      logic       stop;
      logic       osc_fitted;
      logic       ssi_master;
   } rcs_cfg_t;

   // Clock-tree controls towards the PLL and clock gates
   typedef struct packed {
      rcs_ref_t   ref_sel;
      logic       pll_power_down_bit;
      logic       cpu_clk_en;
      logic       codec_from_pll;
      logic       ssi_from_pll;
      logic       sys_on_ref;
   } rcs_clk_ctl_t;

endpackage

/* src/rcs_hold_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_hold_timer #(
   parameter int unsigned CYCLES = `RCS_POR_HOLD_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ce,
   // Control
   input  wire logic restart,
   output var  logic done
);
   localparam int W = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
   } rcs_ht_state_t;

   rcs_ht_state_t st;
   rcs_ht_state_t next_st;

   initial begin
      if (CYCLES < 1) begin
         $error("rcs_hold_timer: CYCLES must be at least 1");
      end
   end

   always_comb begin
      next_st = st;
      if (restart) begin
         next_st.cnt  = '0;
         next_st.done = 1'b0;
      end else if (!st.done) begin
         next_st.cnt = st.cnt + W'(1);
         if (st.cnt == W'(CYCLES - 1)) begin
            next_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign done = st.done;
endmodule

`default_nettype wire

/* src/rcs_strap_latch.sv */
`timescale 1ns/1ps
`default_nettype none

module rcs_strap_latch #(
   parameter int unsigned W = 4
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   // Capture control
   input  wire logic         capture,
   input  wire logic [W-1:0] pin_in,
   output var  logic [W-1:0] value
);
   typedef struct packed {
      logic [W-1:0] value;
   } rcs_sl_state_t;

   rcs_sl_state_t st;
   rcs_sl_state_t next_st;

   initial begin
      if (W < 1) begin
         $error("rcs_strap_latch: W must be at least 1");
      end
   end

   always_comb begin
      next_st = st;
      if (capture) begin
         next_st.value = pin_in;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign value = st.value;
endmodule

`default_nettype wire

/* src/rcs_reset_clock_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_reset_clock_ctl
   import rcs_pkg::*;
#(
   parameter int unsigned STRAP_W   = `RCS_STRAP_W,
   parameter int unsigned REF_BIT   = `RCS_STRAP_REF_BIT,
   parameter int unsigned HOLD_CYC  = `RCS_POR_HOLD_CYC
) (
   // Clock, reset and enable
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic                   ce,
   // Reset sources
   input  wire logic                   power_on_reset_n,
   input  wire logic                   wdt_event,
   // Strap pins
   input  wire logic [STRAP_W-1:0]     strap_in,
   output var  logic [STRAP_W-1:0]     strap_out,
   output var  logic [STRAP_W-1:0]     strap_oe,
   output var  logic                   strap_pull_en,
   output var  logic [STRAP_W-1:0]     strap_value,
   // Configuration from the initializing party
   input  wire rcs_pkg::rcs_cfg_t      cfg,
   // Reset and clock controls
   output var  logic                   sys_reset_n,
   output var  logic                   por_active,
   output var  rcs_pkg::rcs_clk_ctl_t  clk_ctl
);
   import rcs_pkg::*;

   typedef struct packed {
      rcs_state_t   state;
      logic         capture;
      logic         sys_reset_n;
      logic         por_active;
      logic         pull_en;
      rcs_clk_ctl_t ctl;
   } rcs_state_all_t;

   rcs_state_all_t st;
   rcs_state_all_t next_st;

   logic               hold_restart;
   logic               hold_done;
   logic [STRAP_W-1:0] straps;

   initial begin
      if (STRAP_W < 1 || REF_BIT >= STRAP_W) begin
         $error("rcs_reset_clock_ctl: REF_BIT must lie within STRAP_W");
      end
      if (HOLD_CYC < 1) begin
         $error("rcs_reset_clock_ctl: HOLD_CYC must be at least 1");
      end
   end

   // Restart the minimum hold whenever any reset source is active
   assign hold_restart = !power_on_reset_n || wdt_event;

   rcs_hold_timer #(
      .CYCLES (HOLD_CYC)
   ) u_hold (
      .clk     (clk),
      .resetn  (resetn),
      .ce      (ce),
      .restart (hold_restart),
      .done    (hold_done)
   );

   rcs_strap_latch #(
      .W (STRAP_W)
   ) u_straps (
      .clk     (clk),
      .resetn  (resetn),
      .ce      (ce),
      .capture (st.capture),
      .pin_in  (strap_in),
      .value   (straps)
   );

   // Derive the clock tree controls from configuration and stop state
   function automatic rcs_clk_ctl_t clk_tree(input rcs_ref_t r,
                                             input rcs_cfg_t c);
      rcs_clk_ctl_t t;
      t.ref_sel            = r;
      t.pll_power_down_bit = c.stop;
      t.cpu_clk_en         = !c.stop;
      t.sys_on_ref         = c.stop;
      t.codec_from_pll     = !c.osc_fitted && !c.stop;
      t.ssi_from_pll       = c.ssi_master && !c.stop;
      return t;
   endfunction

   always_comb begin
      next_st         = st;
      next_st.capture = 1'b0;
      unique case (st.state)
         RCS_ST_POR: begin
            // Straps float with pulls on while the input is low
            next_st.sys_reset_n = 1'b0;
            next_st.pull_en     = 1'b1;
            next_st.por_active  = 1'b1;
            if (power_on_reset_n) begin
               next_st.capture = 1'b1;
               next_st.state   = RCS_ST_HOLD;
            end
         end
         RCS_ST_HOLD: begin
            next_st.pull_en = 1'b0;
            if (hold_done) begin
               next_st.state = RCS_ST_SYNC;
            end
         end
         RCS_ST_SYNC: begin
            // Load defaults, reference from the strap, then release
            next_st.ctl         = clk_tree(rcs_ref_t'(straps[REF_BIT]),
                                           '0);
            next_st.ctl.pll_power_down_bit = `RCS_PLL_POWER_DOWN_BIT_RESET;
            next_st.sys_reset_n = 1'b1;
            next_st.por_active  = 1'b0;
            next_st.state       = RCS_ST_RUN;
         end
         RCS_ST_RUN: begin
            next_st.ctl = clk_tree(cfg.ref_wr ? cfg.ref_sel : st.ctl.ref_sel,
                                   cfg);
         end
      endcase
      // Watchdog reset: same internal reset, no strap handling
      if (wdt_event && st.state != RCS_ST_POR) begin
         next_st.sys_reset_n = 1'b0;
         next_st.ctl.cpu_clk_en = 1'b0;
         next_st.state       = RCS_ST_HOLD;
      end
      // Power-up reset overrides and includes the watchdog actions
      if (!power_on_reset_n) begin
         next_st.state       = RCS_ST_POR;
         next_st.sys_reset_n = 1'b0;
         next_st.pull_en     = 1'b1;
         next_st.por_active  = 1'b1;
         next_st.ctl.cpu_clk_en = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st                        <= '0;
         st.state                  <= RCS_ST_POR;
         st.pull_en                <= 1'b1;
         st.por_active             <= 1'b1;
         st.ctl.ref_sel            <= rcs_ref_t'(`RCS_REF_RESET);
         st.ctl.pll_power_down_bit <= `RCS_PLL_POWER_DOWN_BIT_RESET;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Strap pins are never driven; pulls are enabled during power-up reset
   assign strap_out     = '0;
   assign strap_oe      = '0;
   assign strap_pull_en = st.pull_en;
   assign strap_value   = straps;
   assign sys_reset_n   = st.sys_reset_n;
   assign por_active    = st.por_active;
   assign clk_ctl       = st.ctl;
endmodule

`default_nettype wire

/* dv/rcs_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module rcs_partner (
   // Board strap resistors
   input  wire logic [3:0] board,
   // Device pin side
   input  wire logic [3:0] strap_out,
   input  wire logic [3:0] strap_oe,
   output var  logic [3:0] strap_in
);
   // crystal ratio to the sample rate is a board choice only
   // Board resistors outvote the internal pulls; a driven pin wins
   assign strap_in = (strap_oe & strap_out) | (~strap_oe & board);
endmodule

`default_nettype wire

/* dv/rcs_reset_clock_ctl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module rcs_asserts
   import rcs_pkg::*;
#(
   parameter int unsigned STRAP_W  = 4,
   parameter int unsigned REF_BIT  = 0,
   parameter int unsigned HOLD_CYC = 20
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   // Inputs
   input  wire logic                  power_on_reset_n,
   input  wire logic                  wdt_event,
   input  wire logic [STRAP_W-1:0]    strap_in,
   input  wire rcs_pkg::rcs_cfg_t     cfg,
   // Outputs
   input  wire logic [STRAP_W-1:0]    strap_out,
   input  wire logic [STRAP_W-1:0]    strap_oe,
   input  wire logic                  strap_pull_en,
   input  wire logic [STRAP_W-1:0]    strap_value,
   input  wire logic                  sys_reset_n,
   input  wire logic                  por_active,
   input  wire rcs_pkg::rcs_clk_ctl_t clk_ctl
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   int unsigned low_cnt;
   logic        run;
   logic        wdt_arm;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= sys_reset_n ? 0 : low_cnt + 1;
      end
   end
   // Running with the enable high; a watchdog request may start from here
   assign wdt_arm = ce && sys_reset_n && power_on_reset_n;
   assign run     = wdt_arm && !wdt_event;
   AST_STRAP_HIZ: assert property (~|strap_oe && ~|strap_out)
      else $error("strap pin driven");
   AST_POR: assert property (!power_on_reset_n |=>
      !sys_reset_n && por_active && strap_pull_en) else $error("por ignored");
   AST_CAPTURE: assert property ($rose(power_on_reset_n) |=> ##1
      !strap_pull_en && strap_value == $past(strap_in))
      else $error("strap capture wrong");
   AST_HOLD: assert property ($rose(sys_reset_n) |->
      low_cnt >= HOLD_CYC) else $error("reset hold too short");
   AST_ALIGN: assert property (por_active |-> !sys_reset_n)
      else $error("released during por");
   AST_WDT: assert property (wdt_arm && wdt_event |=>
      !sys_reset_n && !clk_ctl.cpu_clk_en) else $error("watchdog ignored");
   AST_REF_STRAP: assert property ($rose(sys_reset_n) |->
      clk_ctl.ref_sel == strap_value[REF_BIT]) else $error("ref not strap");
   AST_REF_WR: assert property (run && cfg.ref_wr |=>
      clk_ctl.ref_sel == $past(cfg.ref_sel)) else $error("ref write lost");
   AST_STOP: assert property (run && cfg.stop |=>
      clk_ctl.pll_power_down_bit && !clk_ctl.cpu_clk_en &&
      clk_ctl.sys_on_ref && !clk_ctl.codec_from_pll &&
      !clk_ctl.ssi_from_pll) else $error("stop wrong");
   AST_CODEC: assert property (run && !cfg.stop |=>
      clk_ctl.cpu_clk_en &&
      clk_ctl.codec_from_pll == !$past(cfg.osc_fitted) &&
      clk_ctl.ssi_from_pll == $past(cfg.ssi_master))
      else $error("pll clocks wrong");
endmodule

`default_nettype wire

/* dv/test_reset_and_clock_source_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_reset_and_clock_source_control;
   import rcs_pkg::*;
   localparam int unsigned HOLD = 20;
   logic                clk, resetn, ce, power_on_reset_n, wdt_event, last;
   logic                strap_pull_en, sys_reset_n, por_active;
   logic [3:0]          board, strap_in, strap_out, strap_oe, strap_value;
   rcs_cfg_t            cfg;
   rcs_clk_ctl_t        clk_ctl;
   logic [7:0]          notes[$];
   int                  error_cnt = 0, checks = 0, low_cnt = 0;

   rcs_reset_clock_ctl #(.HOLD_CYC(HOLD)) DUT (.clk, .resetn, .ce,
      .power_on_reset_n, .wdt_event, .strap_in, .strap_out, .strap_oe,
      .strap_pull_en, .strap_value, .cfg, .sys_reset_n, .por_active,
      .clk_ctl);
   rcs_partner u_board (.board, .strap_out, .strap_oe, .strap_in);

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_rel();
      for (int i = 0; i < 8 * HOLD && sys_reset_n !== 1'b1; i++) begin
         @(negedge clk);
      end
      if (sys_reset_n !== 1'b1) begin
         error_cnt++;
         test_done();
      end
   endtask
   task automatic por(logic [3:0] b);
      @(posedge clk);
      power_on_reset_n <= 1'b0;
      board <= b;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("pull", {strap_pull_en, strap_oe}, 8'h10);
      notes.push_back({3'b000, b[0], b});
      @(posedge clk);
      power_on_reset_n <= 1'b1;
      wait_rel();
   endtask

   // Each release of the internal reset takes the oldest note
   always @(negedge clk) begin
      if (!resetn) begin
         low_cnt = 0;
      end else if (!sys_reset_n) begin
         low_cnt++;
      end else if (!last) begin
         check("hold", 8'(low_cnt >= HOLD), 8'h01);
         check("strap", {clk_ctl.ref_sel, strap_value},
            notes.pop_front());
         low_cnt = 0;
      end
      last = sys_reset_n;
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      logic [3:0] b;
      resetn = 1'b0;
      ce = 1'b1;
      power_on_reset_n = 1'b0;
      wdt_event = 1'b0;
      board = 4'h0;
      cfg = '0;
      void'($urandom(32'h3fc0));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         b = {3'($urandom()), i[0]};
         por(b);
      end
      @(posedge clk);
      cfg <= {1'b1, ~b[0], 3'b000};
      @(posedge clk);
      cfg <= '0;
      @(negedge clk);
      check("ref_wr", 8'(clk_ctl.ref_sel), {7'h00, ~b[0]});
      // Enable low must freeze the clock controls against a stop request
      @(posedge clk);
      ce <= 1'b0;
      cfg <= 5'b00100;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("freeze", 8'(clk_ctl.cpu_clk_en), 8'h01);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check("thaw", 8'(clk_ctl.cpu_clk_en), 8'h00);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         cfg <= {2'b00, 3'(k)};
         @(posedge clk);
         @(negedge clk);
         check("ctl", {clk_ctl.pll_power_down_bit, clk_ctl.cpu_clk_en,
            clk_ctl.sys_on_ref, clk_ctl.codec_from_pll, clk_ctl.ssi_from_pll},
            k[2] ? 8'h14 : {6'h02, ~k[1], k[0]});
      end
      @(posedge clk);
      cfg <= '0;
      notes.push_back({3'b000, b[0], b});
      wdt_event <= 1'b1;
      board <= ~b;
      @(posedge clk);
      wdt_event <= 1'b0;
      @(negedge clk);
      wait_rel();
      repeat (4) @(negedge clk);
      test_done();
   end
endmodule

bind rcs_reset_clock_ctl rcs_asserts #(.STRAP_W(STRAP_W), .REF_BIT(REF_BIT),
   .HOLD_CYC(HOLD_CYC)) u_chk (.clk, .resetn, .ce, .power_on_reset_n,
   .wdt_event, .strap_in, .cfg, .strap_out, .strap_oe, .strap_pull_en,
   .strap_value, .sys_reset_n, .por_active, .clk_ctl);

`default_nettype wire
